// file: core/twu_map.svh
// twu_map.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from the timer watchdog package and core
`ifndef TWU_MAP_SVH
`define TWU_MAP_SVH

// wishbone byte addresses, one aligned word each, data in the low byte
`define TWU_ADR_CNT_HI	8'h00
`define TWU_ADR_CNT_LO	8'h04
`define TWU_ADR_PSC	8'h08
`define TWU_ADR_CTL	8'h0c
`define TWU_ADR_WDEN	8'h10

// control register field positions
`define TWU_CTL_RUN	7
`define TWU_CTL_SINGLE	6
`define TWU_CTL_MODE_HI	5
`define TWU_CTL_MODE_LO	4
`define TWU_CTL_INPUT_ENABLE_BIT	3
`define TWU_CTL_OUTPUT_MODE_BIT	2
`define TWU_CTL_OUTPUT_VALUE_BIT	1
`define TWU_CTL_OUTPUT_ENABLE_BIT	0
`define TWU_WDEN_BIT	6

// reset values
`define TWU_CNT_RST	16'hffff
`define TWU_PSC_RST	8'hff
`define TWU_CTL_RST	8'h12
`define TWU_HW_CNT	16'hffff

// refresh key and timing counts
`define TWU_KEY_FIRST	8'haa
`define TWU_KEY_SECOND	8'h55
`define TWU_DIV_LAST	2'h3
`define TWU_STRAP_TAKE	2'h2

`endif

// file: core/twu_pkg.sv
// twu_pkg.sv: types of the timer watchdog unit
// assumes: twu_map.svh on the include path
`include "twu_map.svh"
package twu_pkg;
	typedef enum logic [1:0] {
		twu_in_event  = 2'b00,
		twu_in_gated  = 2'b01,
		twu_in_trig   = 2'b10,
		twu_in_retrig = 2'b11
	} twu_in_mode_e;
endpackage : twu_pkg

// file: core/twu_timer_watchdog.sv
// twu_timer_watchdog.sv: 16-bit timer / watchdog with 8-bit prescaler
// assumes: classic wishbone master on clk_i, pins arrive asynchronous
// Operation
// RULE1 - 16-bit down-counter behind 8-bit prescaler
// RULE2 - input enable counts pin edges, else clock/4
// RULE3 - run bit starts and stops counting
// RULE4 - restart resumes count unless constant rewritten
// RULE5 - constant at next end, prescaler at once
// RULE6 - counter zero is terminal count
// RULE7 - single mode stops, reloads, clears run bit
// RULE8 - continuous mode reloads and keeps counting
// RULE9 - mode bit writable anytime, with run bit
// RULE10 - event mode counts falling edges after start
// RULE11 - gated mode counts clock/4 while pin high
// RULE12 - triggerable mode starts on edge after run
// RULE13 - retriggerable edge reloads, ignored when stopped
// RULE14 - input mode encoding, gated after reset
// RULE15 - output disabled drives pin high
// RULE16 - square mode toggles at terminal count
// RULE17 - pwm mode copies value bit at end
// RULE18 - timer raises end of count interrupt
// RULE19 - strap low: forced watchdog, fixed count
// RULE20 - clearing enable enters watchdog, one way
// RULE21 - watchdog uses clock/4, ignores run bit
// RULE22 - watchdog terminal count gives system reset
// RULE23 - aah then 55h on low byte refreshes
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`include "twu_map.svh"
`default_nettype none
module twu_timer_watchdog (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        event_input_i,
	input  wire logic        hw_watchdog_strap_i,
	output logic             waveform_output_o,
	output logic             eoc_irq_o,
	output logic             sys_reset_o
);
	localparam logic [7:0] CTL_RST = `TWU_CTL_RST;

	////////////////////////////////////////////////////////////////////////
	// state
	logic                     ack_r;
	logic [31:0]              dat_r;
	logic                     ev_s1_r;
	logic                     ev_s2_r;
	logic                     ev_d_r;
	logic                     st_s1_r;
	logic                     st_s2_r;
	logic [1:0]               st_cnt_r;
	logic                     hw_wd_r;
	logic                     wden_n_r;
	logic                     wd_d_r;
	logic [15:0]              cnt_r;
	logic [15:0]              const_r;
	logic                     new_const_r;
	logic [7:0]               psc_r;
	logic [7:0]               psc_cnt_r;
	logic [1:0]               div_r;
	logic                     run_r;
	logic                     run_d_r;
	logic                     single_r;
	twu_pkg::twu_in_mode_e    mode_r;
	logic                     input_enable_bit_r;
	logic                     output_mode_bit_r;
	logic                     output_value_bit_r;
	logic                     output_enable_bit_r;
	logic                     trig_r;
	logic                     key_r;
	logic                     wave_r;
	logic                     irq_r;
	logic                     srst_r;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire       req      = wb_cyc_i & wb_stb_i;
	wire       wr_en    = req & wb_we_i & ack_r & wb_sel_i[0];
	wire [7:0] wd8      = wb_dat_i[7:0];
	wire       sel_hi   = (wb_adr_i == `TWU_ADR_CNT_HI);
	wire       sel_lo   = (wb_adr_i == `TWU_ADR_CNT_LO);
	wire       sel_psc  = (wb_adr_i == `TWU_ADR_PSC);
	wire       sel_ctl  = (wb_adr_i == `TWU_ADR_CTL);
	wire       sel_wden = (wb_adr_i == `TWU_ADR_WDEN);
	wire       wd       = hw_wd_r | ~wden_n_r;
	wire       wr_hi    = wr_en & sel_hi & ~wd;
	wire       wr_lo    = wr_en & sel_lo & ~wd;
	wire       wr_lo_wd = wr_en & sel_lo & wd;
	wire       wr_ctl   = wr_en & sel_ctl & ~wd; // [RULE21]
	wire       wr_psc   = wr_en & sel_psc;
	wire [7:0] ctl_rd   = {run_r, single_r, mode_r, input_enable_bit_r, output_mode_bit_r, output_value_bit_r, output_enable_bit_r};
	wire [7:0] rd_data  = sel_hi   ? cnt_r[15:8] :
	                      sel_lo   ? cnt_r[7:0]  :
	                      sel_psc  ? psc_r       :
	                      sel_ctl  ? ctl_rd      :
	                      sel_wden ? {1'b0, wden_n_r, 6'h00} : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// counting conditions
	wire        fall      = ev_d_r & ~ev_s2_r;
	wire        tick4     = (div_r == `TWU_DIV_LAST);
	wire        ev_mode   = input_enable_bit_r & (mode_r == twu_pkg::twu_in_event);
	wire        src_tick  = (~wd & ev_mode) ? fall : tick4; // [RULE2] [RULE10]
	wire        gate_in   = ~input_enable_bit_r | ev_mode
	                      | ((mode_r == twu_pkg::twu_in_gated) & ev_s2_r) // [RULE11]
	                      | ((mode_r == twu_pkg::twu_in_trig) & trig_r) // [RULE12]
	                      | (mode_r == twu_pkg::twu_in_retrig);
	wire        gate_ok   = wd | (run_r & gate_in); // [RULE3] [RULE21]
	wire        cnt_evt   = src_tick & gate_ok;
	wire        step      = cnt_evt & (psc_cnt_r >= psc_r); // [RULE1] [RULE5]
	wire        eoc       = step & (cnt_r == 16'h0000); // [RULE6]
	wire [15:0] const_eff = hw_wd_r ? `TWU_HW_CNT : const_r; // [RULE19]
	wire        key_hit   = wr_lo_wd & key_r & (wd8 == `TWU_KEY_SECOND); // [RULE23]
	wire        wd_enter  = wd & ~wd_d_r; // [RULE20]
	wire        retrig    = ~wd & run_r & input_enable_bit_r & fall
	                      & (mode_r == twu_pkg::twu_in_retrig); // [RULE13]
	wire        start_ld  = ~wd & run_r & ~run_d_r & new_const_r; // [RULE4]
	wire        any_load  = key_hit | wd_enter | retrig | start_ld;

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			dat_r <= {24'h000000, rd_data};
		end
	end
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; strap is caught once the synchroniser has filled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_s1_r  <= 1'b1;
			ev_s2_r  <= 1'b1;
			ev_d_r   <= 1'b1;
			st_s1_r  <= 1'b1;
			st_s2_r  <= 1'b1;
			st_cnt_r <= 2'h0;
			hw_wd_r  <= 1'b0;
		end else begin
			ev_s1_r <= event_input_i;
			ev_s2_r <= ev_s1_r;
			ev_d_r  <= ev_s2_r;
			st_s1_r <= hw_watchdog_strap_i;
			st_s2_r <= st_s1_r;
			if (st_cnt_r != `TWU_DIV_LAST) begin
				st_cnt_r <= st_cnt_r + 2'h1;
			end
			if (st_cnt_r == `TWU_STRAP_TAKE) begin
				hw_wd_r <= ~st_s2_r; // [RULE19]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// watchdog enable: software may only clear it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wden_n_r <= 1'b1;
			wd_d_r   <= 1'b0;
		end else begin
			wd_d_r <= wd;
			if (wr_en & sel_wden & ~wd8[`TWU_WDEN_BIT]) begin
				wden_n_r <= 1'b0; // [RULE20]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// refresh key; any other low byte write disarms it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_r <= 1'b0;
		end else if (wr_en & sel_lo) begin
			key_r <= (wd8 == `TWU_KEY_FIRST); // [RULE23]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// constant, prescaler value and control bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			const_r     <= `TWU_CNT_RST;
			new_const_r <= 1'b0;
			psc_r       <= `TWU_PSC_RST;
		end else begin
			if (wr_hi) begin
				const_r[15:8] <= wd8;
			end
			if (wr_lo) begin
				const_r[7:0] <= wd8;
			end
			// a fresh write wins over the clear at the load
			if (wr_hi | wr_lo) begin
				new_const_r <= 1'b1;
			end else if (eoc | start_ld | retrig) begin
				new_const_r <= 1'b0;
			end
			if (wr_psc) begin
				psc_r <= wd8; // [RULE5]
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_r    <= CTL_RST[`TWU_CTL_RUN];
			single_r <= CTL_RST[`TWU_CTL_SINGLE];
			mode_r   <= twu_pkg::twu_in_mode_e'(CTL_RST[`TWU_CTL_MODE_HI:`TWU_CTL_MODE_LO]);
			input_enable_bit_r   <= CTL_RST[`TWU_CTL_INPUT_ENABLE_BIT];
			output_mode_bit_r  <= CTL_RST[`TWU_CTL_OUTPUT_MODE_BIT];
			output_value_bit_r  <= CTL_RST[`TWU_CTL_OUTPUT_VALUE_BIT];
			output_enable_bit_r  <= CTL_RST[`TWU_CTL_OUTPUT_ENABLE_BIT];
		end else if (wr_ctl) begin
			run_r    <= wd8[`TWU_CTL_RUN]; // [RULE3] [RULE9]
			single_r <= wd8[`TWU_CTL_SINGLE]; // [RULE9]
			mode_r   <= twu_pkg::twu_in_mode_e'(wd8[`TWU_CTL_MODE_HI:`TWU_CTL_MODE_LO]); // [RULE14]
			input_enable_bit_r   <= wd8[`TWU_CTL_INPUT_ENABLE_BIT];
			output_mode_bit_r  <= wd8[`TWU_CTL_OUTPUT_MODE_BIT];
			output_value_bit_r  <= wd8[`TWU_CTL_OUTPUT_VALUE_BIT];
			output_enable_bit_r  <= wd8[`TWU_CTL_OUTPUT_ENABLE_BIT];
		end else if (eoc & single_r & ~wd) begin
			run_r <= 1'b0; // [RULE7]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clock/4 divider, trigger latch, start edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r   <= 2'h0;
			trig_r  <= 1'b0;
			run_d_r <= 1'b0;
		end else begin
			div_r   <= div_r + 2'h1;
			run_d_r <= run_r;
			if (~run_r) begin
				trig_r <= 1'b0; // [RULE12]
			end else if (fall) begin
				trig_r <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler and counter; lowering the prescaler acts on the next tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psc_cnt_r <= 8'h00;
			cnt_r     <= `TWU_CNT_RST;
		end else begin
			if (any_load | step) begin
				psc_cnt_r <= 8'h00;
			end else if (cnt_evt) begin
				psc_cnt_r <= psc_cnt_r + 8'h01;
			end
			if (key_hit | wd_enter) begin
				cnt_r <= const_eff; // [RULE23] [RULE20]
			end else if (retrig | start_ld) begin
				cnt_r <= const_r; // [RULE13] [RULE4]
			end else if (eoc) begin
				cnt_r <= const_eff; // [RULE7] [RULE8]
			end else if (step) begin
				cnt_r <= cnt_r - 16'h0001; // [RULE1]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// waveform output, interrupt pulse, system reset pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wave_r <= 1'b1;
			irq_r  <= 1'b0;
			srst_r <= 1'b0;
		end else begin
			irq_r  <= eoc & ~wd; // [RULE18]
			srst_r <= eoc & wd; // [RULE22]
			if (eoc & output_mode_bit_r) begin
				wave_r <= output_value_bit_r; // [RULE17]
			end else if (eoc) begin
				wave_r <= ~wave_r; // [RULE16]
			end
		end
	end
	// pin sharing: a disabled output idles high so other functions can drive
	assign waveform_output_o = output_enable_bit_r ? wave_r : 1'b1; // [RULE15]
	assign eoc_irq_o         = irq_r;
	assign sys_reset_o       = srst_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_out_off_high: assert property (!output_enable_bit_r |-> waveform_output_o) // [RULE15]
		else $error("disabled output not high");
	a_tc_reload: assert property (eoc && !any_load |=> cnt_r == $past(const_eff)) // [RULE6]
		else $error("terminal count did not reload");
	a_single_stop: assert property (eoc && single_r && !wd && !wr_ctl |=> !run_r) // [RULE7]
		else $error("single mode kept running");
	a_cont_keep: assert property (eoc && !single_r && run_r && !wr_ctl |=> run_r) // [RULE8]
		else $error("continuous mode stopped");
	a_square_toggle: assert property (eoc && !output_mode_bit_r |=> wave_r != $past(wave_r)) // [RULE16]
		else $error("square output did not toggle");
	a_pwm_copy: assert property (eoc && output_mode_bit_r |=> wave_r == $past(output_value_bit_r)) // [RULE17]
		else $error("pwm output not copied");
	a_pwm_hold: assert property (!eoc |=> $stable(wave_r)) // [RULE17]
		else $error("output changed between ends");
	a_wd_reset: assert property (eoc && wd |=> sys_reset_o && !eoc_irq_o) // [RULE22]
		else $error("watchdog end gave no reset");
	a_timer_irq: assert property (eoc && !wd |=> eoc_irq_o && !sys_reset_o) // [RULE18]
		else $error("timer end gave no interrupt");
	a_hw_fixed: assert property (hw_wd_r && (eoc || key_hit) |=> cnt_r == `TWU_HW_CNT) // [RULE19]
		else $error("hardware watchdog count not fixed");
	a_wden_oneway: assert property (!wden_n_r |=> !wden_n_r) // [RULE20]
		else $error("watchdog enable set again");
	a_key_refresh: assert property (key_hit |=> cnt_r == $past(const_eff)) // [RULE23]
		else $error("refresh did not reload");
	a_count_down: assert property (step && cnt_r != 16'h0000 && !any_load
		|=> cnt_r == $past(cnt_r) - 16'h0001) // [RULE1]
		else $error("counter did not decrement");
	a_stop_hold: assert property (!wd && !run_r && !any_load && !eoc |=> $stable(cnt_r)) // [RULE3]
		else $error("stopped counter moved");
	a_retrig_load: assert property (retrig && !key_hit |=> cnt_r == $past(const_r)) // [RULE13]
		else $error("retrigger did not reload");

	c_wd_expire: cover property (wd && eoc);
	c_single_end: cover property (eoc && single_r && !wd);
	c_refresh: cover property (key_hit);
	c_trig_start: cover property (!trig_r && run_r ##1 trig_r);
endmodule : twu_timer_watchdog
`default_nettype wire

// file: dv/test_timer_watchdog_unit.sv
// test_timer_watchdog_unit.sv: self-checking bench of the timer watchdog
// assumes: one-cycle wishbone ack, 250 MHz clock, pin model on event input
`timescale 1ns/1ns
`include "twu_map.svh"
`default_nettype none
module test_timer_watchdog_unit;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, strap, wv, sel0;
	logic [7:0]  wb_adr_i, pv;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        wb_ack_o, ev, waveform_output_o, eoc_irq_o, sys_reset_o;
	int          mismatches, checks, cycles, irq_cnt, sys_cnt, n, c, p, a, b;
	logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
	logic [7:0]  rv[6] = '{8'hff, 8'hff, 8'hff, 8'h12, 8'h40, 8'h00};
	twu_timer_watchdog twu_timer_watchdog_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.event_input_i(ev), .hw_watchdog_strap_i(strap), .waveform_output_o(waveform_output_o),
		.eoc_irq_o(eoc_irq_o), .sys_reset_o(sys_reset_o));
	twu_pin_model twu_pin_model_inst (.clk_i(clk_i), .event_o(ev));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		irq_cnt += (eoc_irq_o === 1'b1);
		sys_cnt += (sys_reset_o === 1'b1);
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// waits for ack however long it takes; only the cycle ceiling ends a hang
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_sel_i <= {3'($urandom), sel0};
		wb_adr_i <= ad;
		wb_dat_i <= {24'($urandom), d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer
	// edges from the call to the next pulse; lim means no pulse came
	task automatic waitp(input logic sys, input int lim);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (((sys ? sys_reset_o : eoc_irq_o) !== 1'b1) && n < lim);
	endtask : waitp
	task automatic idle(input int k);
		repeat (k) @(posedge clk_i);
	endtask : idle
	task automatic do_reset;
		rst_i <= 1'b1;
		idle(8);
		rst_i <= 1'b0;
		idle(4);
	endtask : do_reset
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'h1;
		sel0 = 1'b1;
		strap = 1'b1;
		rst_i = 1'b1;
		void'($urandom(30));
		do_reset();
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, ra[i], 8'h00);
			chk(rd, {24'h000000, rv[i]});
		end
		chk(waveform_output_o, 1'b1);
		// a write without its byte lane must leave the register alone
		sel0 = 1'b0;
		xfer(1'b1, `TWU_ADR_PSC, 8'h00);
		sel0 = 1'b1;
		xfer(1'b0, `TWU_ADR_PSC, 8'h00);
		chk(rd, {24'h000000, `TWU_PSC_RST});
		c = $urandom % 6;
		p = $urandom % 3;
		xfer(1'b1, `TWU_ADR_CNT_LO, c[7:0]);
		xfer(1'b1, `TWU_ADR_CNT_HI, 8'h00);
		xfer(1'b1, `TWU_ADR_PSC, p[7:0]);
		xfer(1'b1, `TWU_ADR_CTL, 8'h81);
		waitp(1'b0, 500);
		wv = waveform_output_o;
		waitp(1'b0, 500);
		chk(n, (c + 1) * 4 * (p + 1));
		chk(waveform_output_o, !wv);
		pv = 8'(p + 1);
		xfer(1'b1, `TWU_ADR_PSC, pv);
		waitp(1'b0, 500);
		waitp(1'b0, 500);
		chk(n, (c + 1) * 4 * (p + 2));
		xfer(1'b1, `TWU_ADR_CTL, 8'h85);
		waitp(1'b0, 500);
		waitp(1'b0, 500);
		chk(waveform_output_o, 1'b0);
		xfer(1'b1, `TWU_ADR_CTL, 8'h87);
		waitp(1'b0, 500);
		waitp(1'b0, 500);
		chk(waveform_output_o, 1'b1);
		xfer(1'b1, `TWU_ADR_CTL, 8'h00);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		a = rd;
		idle(40);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd, a);
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'h03);
		xfer(1'b1, `TWU_ADR_CTL, 8'hc1);
		waitp(1'b0, 500);
		idle(2);
		xfer(1'b0, `TWU_ADR_CTL, 8'h00);
		chk(rd, 32'h00000041);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd, 32'h00000003);
		a = irq_cnt;
		idle(80);
		chk(irq_cnt, a);
		xfer(1'b1, `TWU_ADR_PSC, 8'h00);
		// event counting: the second fall after start reaches zero, the third gives the end of count
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'h02);
		xfer(1'b1, `TWU_ADR_CTL, 8'h88);
		a = irq_cnt;
		twu_pin_model_inst.falls(2);
		idle(6);
		chk(irq_cnt, a);
		twu_pin_model_inst.falls(1);
		idle(6);
		chk(irq_cnt, a + 1);
		xfer(1'b1, `TWU_ADR_CTL, 8'h00);
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'hf0);
		twu_pin_model_inst.level(1'b0);
		xfer(1'b1, `TWU_ADR_CTL, 8'h98);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		a = rd;
		idle(40);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd, a);
		twu_pin_model_inst.level(1'b1);
		idle(40);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd !== a, 1'b1);
		xfer(1'b1, `TWU_ADR_CTL, 8'h00);
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'hf0);
		xfer(1'b1, `TWU_ADR_CTL, 8'ha8);
		idle(40);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd, 32'h000000f0);
		twu_pin_model_inst.falls(1);
		idle(40);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd !== 32'h000000f0, 1'b1);
		xfer(1'b1, `TWU_ADR_CTL, 8'h00);
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'hf0);
		xfer(1'b1, `TWU_ADR_CTL, 8'hb8);
		idle(200);
		twu_pin_model_inst.falls(1);
		idle(4);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd > 32'h000000e8, 1'b1);
		xfer(1'b1, `TWU_ADR_CTL, 8'h38);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		a = rd;
		twu_pin_model_inst.falls(1);
		idle(6);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd, a);
		// time base first, then enter watchdog with the run bit clear
		xfer(1'b1, `TWU_ADR_CNT_LO, 8'h10);
		xfer(1'b1, `TWU_ADR_CNT_HI, 8'h00);
		xfer(1'b1, `TWU_ADR_WDEN, 8'h00);
		a = sys_cnt;
		b = irq_cnt;
		repeat (4) begin
			idle(20);
			xfer(1'b1, `TWU_ADR_CNT_LO, `TWU_KEY_FIRST);
			xfer(1'b1, `TWU_ADR_CNT_LO, `TWU_KEY_SECOND);
		end
		chk(sys_cnt, a);
		xfer(1'b1, `TWU_ADR_WDEN, 8'h40);
		xfer(1'b0, `TWU_ADR_WDEN, 8'h00);
		chk(rd, 32'h00000000);
		waitp(1'b1, 200);
		waitp(1'b1, 200);
		chk(n, 68);
		chk(irq_cnt, b);
		strap <= 1'b0;
		do_reset();
		xfer(1'b0, `TWU_ADR_WDEN, 8'h00);
		chk(rd, 32'h00000040);
		xfer(1'b1, `TWU_ADR_CNT_HI, 8'h00);
		xfer(1'b0, `TWU_ADR_CNT_HI, 8'h00);
		chk(rd, 32'h000000ff);
		// prescaler stays writable; at reset value no step would come for ages
		xfer(1'b1, `TWU_ADR_PSC, 8'h00);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		a = rd;
		idle(20);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd !== a, 1'b1);
		a = rd;
		xfer(1'b1, `TWU_ADR_CNT_LO, `TWU_KEY_FIRST);
		xfer(1'b1, `TWU_ADR_CNT_LO, `TWU_KEY_SECOND);
		xfer(1'b0, `TWU_ADR_CNT_LO, 8'h00);
		chk(rd > a, 1'b1);
		tally_and_finish();
	end
endmodule : test_timer_watchdog_unit
`default_nettype wire

// file: dv/twu_pin_model.sv
// twu_pin_model.sv: far-side model of the event pin
// assumes: shares the bench clock; callers keep edges well spaced
`timescale 1ns/1ns
`default_nettype none
module twu_pin_model (
	input  wire logic clk_i,
	output logic      event_o
);
	initial event_o = 1'b1;
	////////////////////////////////////////////////////////////////
	// ten clocks between falls, well clear of the minimum spacing
	task automatic falls(input int n);
		repeat (n) begin
			repeat (5) @(posedge clk_i);
			event_o <= 1'b0;
			repeat (5) @(posedge clk_i);
			event_o <= 1'b1;
		end
	endtask : falls
	// level changes are rare, so the pin never outruns clock/8
	task automatic level(input logic v);
		@(posedge clk_i);
		event_o <= v;
	endtask : level
endmodule : twu_pin_model
`default_nettype wire
